//--- shared/pgdt_consts.vh
/*
 constants for the pulse gap delay timer: tick periods, counter widths,
 start values and base select codes. assumes a 10 MHz system clock.
*/
`ifndef PGDT_CONSTS_VH
`define PGDT_CONSTS_VH

`define PGDT_CLK_HZ 10000000
`define PGDT_TICK_1MS_CYC (`PGDT_CLK_HZ / 1000)
`define PGDT_PRE_W 14
`define PGDT_PRE_1MS 14'h270f
`define PGDT_DEC_W 7
`define PGDT_DEC_10 7'h09
`define PGDT_DEC_100 7'h63
`define PGDT_BASE_W 2
`define PGDT_BASE_100MS 2'h0
`define PGDT_BASE_10MS 2'h1
`define PGDT_BASE_1MS 2'h2
`define PGDT_CNT_W 14
`define PGDT_MEAS_START 14'h270f
`define PGDT_ZERO 14'h0000
`define PGDT_ONE 14'h0001

`endif

//--- rtl/pgdt_tick_gen.v
/*
 tick generator: one-cycle strobes every 1 ms, 10 ms and 100 ms.
 assumes clk_in at the rate named in the constants header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pgdt_consts.vh"

module pgdt_tick_gen (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // tick strobes
    output reg tick_1ms_out,
    output reg tick_10ms_out,
    output reg tick_100ms_out
);
    reg [`PGDT_PRE_W-1:0] pre_r;
    reg [`PGDT_DEC_W-1:0] div10_r;
    reg [`PGDT_DEC_W-1:0] div100_r;
    wire ms_w;

    assign ms_w = (pre_r == `PGDT_PRE_1MS);

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_r <= {`PGDT_PRE_W{1'b0}};
            div10_r <= {`PGDT_DEC_W{1'b0}};
            div100_r <= {`PGDT_DEC_W{1'b0}};
            tick_1ms_out <= 1'b0;
            tick_10ms_out <= 1'b0;
            tick_100ms_out <= 1'b0;
        end else begin
            pre_r <= ms_w ? {`PGDT_PRE_W{1'b0}} : pre_r + 1'b1;
            tick_1ms_out <= ms_w;
            tick_10ms_out <= ms_w && (div10_r == `PGDT_DEC_10);
            tick_100ms_out <= ms_w && (div100_r == `PGDT_DEC_100);
            if (ms_w) begin
                div10_r <= (div10_r == `PGDT_DEC_10) ? {`PGDT_DEC_W{1'b0}} : div10_r + 1'b1;
                div100_r <= (div100_r == `PGDT_DEC_100) ? {`PGDT_DEC_W{1'b0}} : div100_r + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/pgdt_top.v
/*
 pulse gap delay timer: measures the low gap of an external pulse source,
 turns it into a preset and runs a delay timer from it on a start input.
 assumes pulse and start inputs already synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pgdt_consts.vh"

// Operation
// (R1) source pulses 80 ms, gap 20 ms-2 s
// (R2) gap timer counts down from 9999 while low
// (R3) on rise, preset = 9999 minus count
// (R4) minuend equals start; read before reload
// (R5) start high: delay timer counts from preset
// (R6) delay timeout asserts done output
// (R7) each timer selects 100/10/1 ms base
// (R8) no 20 ms gap on 100 ms base
// (R9) new preset active about 2 s later
// (R10) 10 ms/100 ms gives 0.2-20 s delay
// (R11) one capture per rise; reload while high
module pgdt_top (
    // clock and reset
    input wire clk_in,
    input wire reset_in,
    // tick base selects
    input wire [`PGDT_BASE_W-1:0] measure_base_in,
    input wire [`PGDT_BASE_W-1:0] delay_base_in,
    // field inputs
    input wire pulse_source_input_in,
    input wire delay_start_input_in,
    // results
    output reg delay_done_output_out,
    output reg [`PGDT_CNT_W-1:0] captured_preset_reg_out,
    output reg [`PGDT_CNT_W-1:0] gap_timer_count_out,
    output reg [`PGDT_CNT_W-1:0] delay_timer_count_out
);
    localparam [`PGDT_CNT_W-1:0] MINUEND_OPERAND = `PGDT_MEAS_START;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;
    localparam integer NUM_TIMERS = 2;
    localparam integer SEL_MEAS = 0;
    localparam integer SEL_DELAY = 1;

    // shared tick strobes
    wire t1_w;
    wire t10_w;
    wire t100_w;

    // per-timer base codes and selected ticks: slot 0 gap, slot 1 delay
    wire [`PGDT_BASE_W*NUM_TIMERS-1:0] base_bus_w;
    wire [NUM_TIMERS-1:0] tick_bus_w;
    wire meas_tick_w;
    wire delay_tick_w;

    // pulse edge and gap measurement
    reg pulse_prev_r;
    wire pulse_high_w;
    wire pulse_rise_w;
    wire gap_floor_w;
    reg [`PGDT_CNT_W-1:0] gap_count_nxt;
    reg [`PGDT_CNT_W-1:0] preset_nxt;

    // delay timer, one-hot states
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [`PGDT_CNT_W-1:0] delay_count_nxt;
    reg done_nxt;
    wire preset_zero_w;
    wire delay_floor_w;
    wire delay_last_w;

    // code 3 is unused; it falls back to the 10 ms base
    function tick_sel;
        input [`PGDT_BASE_W-1:0] base;
        input a100;
        input a10;
        input a1;
        begin
            case (base)
                `PGDT_BASE_100MS: tick_sel = a100;
                `PGDT_BASE_10MS: tick_sel = a10;
                `PGDT_BASE_1MS: tick_sel = a1;
                default: tick_sel = a10;
            endcase
        end
    endfunction

    pgdt_tick_gen u_ticks (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .tick_1ms_out(t1_w),
        .tick_10ms_out(t10_w),
        .tick_100ms_out(t100_w)
    );

    // one selector per timer so the two bases stay independent
    assign base_bus_w = {delay_base_in, measure_base_in};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi = gi + 1) begin : g_tick_sel
            assign tick_bus_w[gi] = tick_sel(base_bus_w[gi*`PGDT_BASE_W +: `PGDT_BASE_W],
                t100_w, t10_w, t1_w); // [R7]
        end
    endgenerate

    assign meas_tick_w = tick_bus_w[SEL_MEAS];
    assign delay_tick_w = tick_bus_w[SEL_DELAY];

    // prev resets to the idle low level, so no false rise after reset
    assign pulse_high_w = pulse_source_input_in;
    assign pulse_rise_w = pulse_high_w && !pulse_prev_r;
    assign gap_floor_w = (gap_timer_count_out == `PGDT_ZERO);

    // capture reads the count held before this edge, so the reload
    // below cannot corrupt it
    always @* begin
        preset_nxt = captured_preset_reg_out;
        if (pulse_rise_w) begin
            preset_nxt = MINUEND_OPERAND - gap_timer_count_out; // [R3] [R4] [R11]
        end
    end

    // saturates at zero rather than wrapping into a huge preset
    always @* begin
        gap_count_nxt = gap_timer_count_out;
        if (pulse_high_w) begin
            gap_count_nxt = `PGDT_MEAS_START; // [R11]
        end else if (meas_tick_w && !gap_floor_w) begin
            gap_count_nxt = gap_timer_count_out - `PGDT_ONE; // [R2]
        end
    end

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pulse_prev_r <= 1'b0;
            gap_timer_count_out <= `PGDT_MEAS_START;
            captured_preset_reg_out <= `PGDT_ZERO;
        end else begin
            pulse_prev_r <= pulse_high_w;
            gap_timer_count_out <= gap_count_nxt;
            captured_preset_reg_out <= preset_nxt;
        end
    end

    // delay timer: preset is loaded at start, so a new capture only
    // counts for the next start; a gap under one tick gives preset 0
    assign preset_zero_w = (captured_preset_reg_out == `PGDT_ZERO);
    assign delay_floor_w = (delay_timer_count_out == `PGDT_ZERO);
    assign delay_last_w = delay_tick_w && (delay_timer_count_out == `PGDT_ONE);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (delay_start_input_in) begin
                    if (preset_zero_w) begin
                        state_nxt = ST_DONE;
                    end else begin
                        state_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!delay_start_input_in) begin
                    state_nxt = ST_IDLE;
                end else if (delay_last_w) begin
                    state_nxt = ST_DONE; // [R6]
                end
            end
            ST_DONE: begin
                if (!delay_start_input_in) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // start low reloads the preset so a restart begins from the full count
    always @* begin
        delay_count_nxt = delay_timer_count_out;
        case (state_r)
            ST_IDLE: begin
                delay_count_nxt = captured_preset_reg_out; // [R5] [R9] [R10]
            end
            ST_RUN: begin
                if (!delay_start_input_in) begin
                    delay_count_nxt = captured_preset_reg_out;
                end else if (delay_tick_w && !delay_floor_w) begin
                    delay_count_nxt = delay_timer_count_out - `PGDT_ONE; // [R5]
                end
            end
            ST_DONE: begin
                delay_count_nxt = `PGDT_ZERO;
            end
            default: begin
                delay_count_nxt = `PGDT_ZERO;
            end
        endcase
    end

    always @* begin
        done_nxt = (state_nxt == ST_DONE); // [R6]
    end

    // registered outputs; done follows the state it will enter
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= ST_IDLE;
            delay_timer_count_out <= `PGDT_ZERO;
            delay_done_output_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            delay_timer_count_out <= delay_count_nxt;
            delay_done_output_out <= done_nxt;
        end
    end
endmodule
`default_nettype wire

//--- tb/pgdt_top_monitor.sv
/* checker on pgdt_top ports; bound to every pgdt_top instance */
`timescale 1ns/1ps
`default_nettype none
`include "pgdt_consts.vh"
module pgdt_top_monitor (
    // watched ports
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pulse_source_input_in,
    input wire logic delay_start_input_in,
    input wire logic delay_done_output_out,
    input wire logic [13:0] captured_preset_reg_out,
    input wire logic [13:0] gap_timer_count_out,
    input wire logic [13:0] delay_timer_count_out
);
    wire p = pulse_source_input_in;
    wire s = delay_start_input_in;
    wire d = delay_done_output_out;
    wire [13:0] pre = captured_preset_reg_out;
    wire [13:0] g = gap_timer_count_out;
    wire [13:0] dc = delay_timer_count_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_reload; p |=> g == `PGDT_MEAS_START; endproperty
    a_reload: assert property (p_reload) else $error("gap count not reloaded");
    property p_capt; $rose(p) |=> pre == `PGDT_MEAS_START - $past(g); endproperty
    a_capt: assert property (p_capt) else $error("preset capture wrong");
    property p_down; !p |=> g == $past(g) || g == $past(g) - 14'h1; endproperty
    a_down: assert property (p_down) else $error("gap count step wrong");
    property p_keep; !$rose(p) |=> $stable(pre); endproperty
    a_keep: assert property (p_keep) else $error("preset moved");
    property p_done; $rose(d) |-> dc == 14'h0 && $past(s); endproperty
    a_done: assert property (p_done) else $error("done without timeout");
    property p_idle; !s |=> !d; endproperty
    a_idle: assert property (p_idle) else $error("done while idle");
    property p_load; $rose(s) |-> dc == pre; endproperty
    a_load: assert property (p_load) else $error("delay not loaded");
    property p_run; s && $past(s) |-> dc <= $past(dc); endproperty
    a_run: assert property (p_run) else $error("delay count rose");
    // ticks are far apart, so two steps in a row mean a broken divider
    property p_rate; $changed(g) && !p |=> $stable(g) || p; endproperty
    a_rate: assert property (p_rate) else $error("gap ticks too close");
    c_capt: cover property ($rose(p));
    c_start: cover property ($rose(s));
    c_done: cover property ($rose(d));
    c_zero: cover property ($rose(s) && pre == 14'h0);
endmodule
bind pgdt_top pgdt_top_monitor mon_u (.clk_in(clk_in), .reset_in(reset_in),
    .pulse_source_input_in(pulse_source_input_in), .delay_start_input_in(delay_start_input_in),
    .delay_done_output_out(delay_done_output_out), .captured_preset_reg_out(captured_preset_reg_out),
    .gap_timer_count_out(gap_timer_count_out), .delay_timer_count_out(delay_timer_count_out));
`default_nettype wire

//--- tb/pgdt_pulse_model.sv
/* pulse source model: low gap then short high pulse, repeating; needs reset */
`timescale 1ns/1ps
`default_nettype none
module pgdt_pulse_model #(parameter int GAP = 35000, parameter int HIGH = 800) (
    input wire logic clk_in,
    input wire logic reset_in,
    output logic pulse_out = 1'b0
);
    int n = 0;
    // gap shortened to fit the run; never paired with the 100 ms base
    always @(negedge clk_in) begin
        n = reset_in ? 0 : (n + 1) % (GAP + HIGH);
        pulse_out <= (n >= GAP);
    end
endmodule
`default_nettype wire

//--- tb/pgdt_top_bench.sv
/* bench for pgdt_top; 1 ms delay base, 1 ms then 10 ms gap base, so two gaps and one delay fit the run */
`timescale 1ns/1ps
`default_nettype none
`include "pgdt_consts.vh"
module pgdt_top_bench;
    logic clk_in = 1'b0, reset_in = 1'b1, start = 1'b0, pulse, done;
    logic [13:0] pre, gap, dcnt;
    logic [1:0] mbase = `PGDT_BASE_1MS;
    int bad_count = 0, tests_run = 0, cyc = 0, i;
    always #50 clk_in = ~clk_in;
    pgdt_pulse_model src_u (.clk_in(clk_in), .reset_in(reset_in), .pulse_out(pulse));
    pgdt_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .measure_base_in(mbase),
        .delay_base_in(`PGDT_BASE_1MS), .pulse_source_input_in(pulse), .delay_start_input_in(start),
        .delay_done_output_out(done), .captured_preset_reg_out(pre), .gap_timer_count_out(gap),
        .delay_timer_count_out(dcnt));
    task check(input logic [13:0] seen, input logic [13:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            results();
        end
    end
    task t_capture;
        for (i = 0; i < 40000 && pulse !== 1'b1; i++) @(negedge clk_in);
        repeat (2) @(negedge clk_in);
        check(pre, 14'd3);
        check(gap, `PGDT_MEAS_START);
        // next gap on the 10 ms base: shorter than one tick, preset 0
        mbase <= `PGDT_BASE_10MS;
        $display("capture done");
    endtask
    task t_short;
        for (i = 0; i < 40000 && pulse !== 1'b1; i++) @(negedge clk_in);
        repeat (2) @(negedge clk_in);
        check(pre, `PGDT_ZERO);
        start <= 1'b1;
        repeat (2) @(negedge clk_in);
        check(done, 1'b1);
        check(dcnt, `PGDT_ZERO);
        start <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(done, 1'b0);
        $display("short gap done");
    endtask
    task t_delay;
        start <= 1'b1;
        @(negedge clk_in);
        check(dcnt, 14'd3);
        for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk_in);
        check(done, 1'b1);
        check(dcnt, 14'h0);
        check(i >= 19999 && i <= 30001, 1'b1);
        $display("delay done");
    endtask
    task t_stop;
        start <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(done, 1'b0);
        check(dcnt, 14'd3);
        $display("stop done");
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        reset_in <= 1'b0;
        t_capture();
        t_delay();
        t_stop();
        t_short();
        results();
    end
endmodule
`default_nettype wire
